// >>> common/cfg_pkg.sv
// Constants shared by the configuration, interrupt and activity logic.
// Assumes a single device clock at the rate given below.
`default_nettype none
package cfg_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] TOP_CFG_OFFSET = 16'h0000;
    localparam logic [REG_W-1:0] TOP_CFG_RESET = 16'h0000;
    localparam int TX_ONLY_BIT = 3;
    localparam int IRQ_STYLE_BIT = 2;
    localparam int MON_ACT_BIT = 1;
    localparam int RESERVED_BIT = 0;
    localparam int NUM_RT = 2;
    // Timing, in nanoseconds as given, then in clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int IRQ_PULSE_NS = 1000;
    localparam int ACK_MIN_NS = 250;
    // Pulse is a least width, acknowledge a least width: both round up
    localparam int IRQ_PULSE_CYC =
        (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_MIN_CYC =
        (ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_HOLD} irq_state_t;
endpackage
`default_nettype wire

// >>> common/irq_if.sv
// Carrier between the configuration block and the interrupt pin generator.
// All signals are on the device clock.
`default_nettype none
interface irq_if;
    logic event_pulse;
    logic level_style;
    logic ack_level;
    logic irq_n;
    modport ctrl (output event_pulse, output level_style,
                  output ack_level, input irq_n);
    modport gen (input event_pulse, input level_style,
                 input ack_level, output irq_n);
endinterface
`default_nettype wire

// >>> logic/config_irq_activity_ctrl.sv
// Low control bits of the top-level configuration register, the bus
// shutdown bookkeeping of the remote terminals, the interrupt pin style
// and the activity output. Mode code strobes, inhibit bits and activity
// flags come from logic on the same clock; the acknowledge is a pin.
// Function
// - Host-managed shutdown off: device fulfils selected-bus shutdown and override itself.
// - Host-managed shutdown on: device ignores those two mode codes.
// - Pulse style: each enabled interrupt event starts or restarts an active-low 1us pulse.
// - Level style: request held low until host acknowledges, then high.
// - Report bit off: monitor activity alone does not assert activity.
// - Report bit on: enabled monitor activity is ORed into activity output.
// - Bit 0 has no function and always reads zero.
// - Transmit-only bit clear blocks both directions; set blocks transmit only.
`default_nettype none
module config_irq_activity_ctrl #(
    parameter int NRT = cfg_pkg::NUM_RT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Host register port
    input wire logic host_wr,
    input wire logic [cfg_pkg::ADDR_W-1:0] host_addr,
    input wire logic [cfg_pkg::REG_W-1:0] host_wdata,
    output logic [cfg_pkg::REG_W-1:0] host_rdata,
    // Remote terminal shutdown controls
    input wire logic [NRT-1:0] host_managed_shutdown,
    input wire logic [NRT-1:0] bus_a_inhibit,
    input wire logic [NRT-1:0] bus_b_inhibit,
    input wire logic [NRT-1:0] sel_shutdown_mc,
    input wire logic [NRT-1:0] sel_override_mc,
    input wire logic [NRT-1:0] sel_bus_is_b,
    output logic [NRT-1:0] tx_block_a,
    output logic [NRT-1:0] rx_block_a,
    output logic [NRT-1:0] tx_block_b,
    output logic [NRT-1:0] rx_block_b,
    // Interrupt pins
    input wire logic irq_event,
    input wire logic interrupt_acknowledge_in,
    output logic interrupt_request_n,
    // Activity
    input wire logic terminal_active,
    input wire logic monitor_active,
    input wire logic monitor_other_involved,
    output logic activity
);
    import cfg_pkg::*;

    logic shutdown_transmit_only_sel;
    logic interrupt_style_select;
    logic monitor_activity_report;
    logic [NRT-1:0] auto_inh_a;
    logic [NRT-1:0] auto_inh_b;
    logic ack_meta;
    logic ack_sync;

    irq_if irq_link ();

    // Register decode
    wire logic addr_hit = (host_addr == TOP_CFG_OFFSET);
    wire logic cfg_wr = host_wr && addr_hit;
    wire logic [REG_W-1:0] cfg_view =
        (REG_W'(shutdown_transmit_only_sel) << TX_ONLY_BIT) |
        (REG_W'(interrupt_style_select) << IRQ_STYLE_BIT) |
        (REG_W'(monitor_activity_report) << MON_ACT_BIT);
    // Bit 0 is never stored, so it reads zero
    wire logic [REG_W-1:0] next_rdata = addr_hit ? cfg_view : '0;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shutdown_transmit_only_sel <= TOP_CFG_RESET[TX_ONLY_BIT];
            interrupt_style_select <= TOP_CFG_RESET[IRQ_STYLE_BIT];
            monitor_activity_report <= TOP_CFG_RESET[MON_ACT_BIT];
        end
        else if (cfg_wr)
        begin
            shutdown_transmit_only_sel <= host_wdata[TX_ONLY_BIT];
            interrupt_style_select <= host_wdata[IRQ_STYLE_BIT];
            monitor_activity_report <= host_wdata[MON_ACT_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            host_rdata <= '0;
        else
            host_rdata <= next_rdata;
    end

    // Automatic selected-bus shutdown; host-managed terminals keep state
    wire logic [NRT-1:0] auto_ok = ~host_managed_shutdown;
    wire logic [NRT-1:0] set_a = sel_shutdown_mc & ~sel_bus_is_b & auto_ok;
    wire logic [NRT-1:0] set_b = sel_shutdown_mc & sel_bus_is_b & auto_ok;
    wire logic [NRT-1:0] clr_a = sel_override_mc & ~sel_bus_is_b & auto_ok;
    wire logic [NRT-1:0] clr_b = sel_override_mc & sel_bus_is_b & auto_ok;
    // Shutdown wins if both codes land together
    wire logic [NRT-1:0] next_auto_a = (auto_inh_a & ~clr_a) | set_a;
    wire logic [NRT-1:0] next_auto_b = (auto_inh_b & ~clr_b) | set_b;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            auto_inh_a <= '0;
            auto_inh_b <= '0;
        end
        else
        begin
            auto_inh_a <= next_auto_a;
            auto_inh_b <= next_auto_b;
        end
    end

    // Host inhibit writes act whatever the automation setting
    wire logic [NRT-1:0] inh_a = bus_a_inhibit | auto_inh_a;
    wire logic [NRT-1:0] inh_b = bus_b_inhibit | auto_inh_b;
    wire logic [NRT-1:0] rx_gate = {NRT{~shutdown_transmit_only_sel}};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_block_a <= '0;
            tx_block_b <= '0;
            rx_block_a <= '0;
            rx_block_b <= '0;
        end
        else
        begin
            tx_block_a <= inh_a;
            tx_block_b <= inh_b;
            rx_block_a <= inh_a & rx_gate;
            rx_block_b <= inh_b & rx_gate;
        end
    end

    // Acknowledge pin is asynchronous; only ack_sync feeds logic
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end
        else
        begin
            ack_meta <= interrupt_acknowledge_in;
            ack_sync <= ack_meta;
        end
    end

    assign irq_link.event_pulse = irq_event;
    assign irq_link.level_style = interrupt_style_select;
    assign irq_link.ack_level = ack_sync;
    assign interrupt_request_n = irq_link.irq_n;

    irq_pin_gen u_irq (
        .clk(clk),
        .arst_n(arst_n),
        .port(irq_link.gen)
    );

    // Monitor activity counts only when reported or shared with a terminal
    wire logic mon_counts = monitor_active &&
        (monitor_activity_report || monitor_other_involved);
    wire logic next_activity = terminal_active || mon_counts;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            activity <= 1'b0;
        else
            activity <= next_activity;
    end

    a_auto_shutdown: assert property (@(posedge clk) disable iff (!arst_n)
        (|set_a) |=> ((auto_inh_a & $past(set_a)) == $past(set_a)))
        else $error("automatic shutdown not taken");
    a_auto_override: assert property (@(posedge clk) disable iff (!arst_n)
        (|(clr_b & ~set_b))
        |=> ((auto_inh_b & $past(clr_b & ~set_b)) == '0))
        else $error("automatic override not taken");
    a_host_managed: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (((auto_inh_a ^ $past(auto_inh_a)) |
              (auto_inh_b ^ $past(auto_inh_b)))
             & $past(host_managed_shutdown)) == '0)
        else $error("host-managed terminal changed on its own");
    a_tx_only_rx: assert property (@(posedge clk) disable iff (!arst_n)
        shutdown_transmit_only_sel |=> (rx_block_a == '0 &&
            rx_block_b == '0))
        else $error("receive blocked in transmit-only mode");
    a_full_block: assert property (@(posedge clk) disable iff (!arst_n)
        !shutdown_transmit_only_sel |=> (rx_block_a == tx_block_a &&
            rx_block_b == tx_block_b))
        else $error("receive and transmit blocks differ");
    a_host_inhibit: assert property (@(posedge clk) disable iff (!arst_n)
        (|bus_a_inhibit) |=> ((tx_block_a & $past(bus_a_inhibit)) ==
            $past(bus_a_inhibit)))
        else $error("host inhibit did not block transmit");
    a_mon_silent: assert property (@(posedge clk) disable iff (!arst_n)
        (!monitor_activity_report && !monitor_other_involved &&
         !terminal_active) |=> !activity)
        else $error("unreported monitor activity shown");
    a_mon_report: assert property (@(posedge clk) disable iff (!arst_n)
        (monitor_activity_report && monitor_active) |=> activity)
        else $error("reported monitor activity missing");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
        host_rdata[RESERVED_BIT] == 1'b0 &&
        host_rdata[REG_W-1:TX_ONLY_BIT+1] == '0)
        else $error("unused bits read nonzero");
    a_cfg_write: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_wr ##1 addr_hit |=> (host_rdata[TX_ONLY_BIT:MON_ACT_BIT] ==
            $past(host_wdata[TX_ONLY_BIT:MON_ACT_BIT], 2)))
        else $error("written configuration not read back");
    a_pulse_low: assert property (@(posedge clk) disable iff (!arst_n)
        (interrupt_request_n && irq_event)
        |=> !interrupt_request_n)
        else $error("event did not lower interrupt request");
endmodule
`default_nettype wire

// >>> logic/irq_pin_gen.sv
// Drives the active-low interrupt request as a timed pulse or a held level.
// Expects a synchronised acknowledge level and a one-cycle event strobe.
`default_nettype none
module irq_pin_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control side
    irq_if.gen port
);
    import cfg_pkg::*;
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(IRQ_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(ACK_MIN_CYC - 1);
    localparam int PULSE_MAX = IRQ_PULSE_CYC;

    irq_state_t state;
    irq_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] ack_cnt;
    logic [CNT_W-1:0] next_ack_cnt;
    logic irq_n_q;

    // Held long enough once the acknowledge has stood ACK_MIN_CYC cycles
    wire logic ack_done = port.ack_level && (ack_cnt == ACK_LAST);
    wire logic pulse_done = (cnt == '0);

    assign next_ack_cnt = !port.ack_level ? '0 :
                          (ack_cnt == ACK_LAST) ? ack_cnt :
                          CNT_W'(ack_cnt + 1'b1);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            IRQ_IDLE:
            begin
                if (port.event_pulse)
                begin
                    next_state = port.level_style ? IRQ_HOLD : IRQ_PULSE;
                    next_cnt = PULSE_LAST;
                end
            end
            IRQ_PULSE:
            begin
                // A new event restarts the pulse rather than being lost
                if (port.event_pulse)
                    next_cnt = PULSE_LAST;
                else if (pulse_done)
                    next_state = IRQ_IDLE;
                else
                    next_cnt = CNT_W'(cnt - 1'b1);
            end
            IRQ_HOLD:
            begin
                // An event in the release cycle wins over the acknowledge
                if (ack_done && !port.event_pulse)
                    next_state = IRQ_IDLE;
            end
            // The fourth code of the state word is unused: recover to idle
            default:
            begin
                next_state = IRQ_IDLE;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= IRQ_IDLE;
            cnt <= '0;
            ack_cnt <= '0;
            irq_n_q <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            // A fresh event demands a fresh acknowledge
            ack_cnt <= port.event_pulse ? '0 : next_ack_cnt;
            irq_n_q <= (next_state == IRQ_IDLE);
        end
    end

    assign port.irq_n = irq_n_q;

    a_pulse_start: assert property (@(posedge clk) disable iff (!arst_n)
        (state == IRQ_IDLE && port.event_pulse && !port.level_style)
        |=> (!port.irq_n && cnt == PULSE_LAST))
        else $error("pulse did not start at full width");
    a_pulse_end: assert property (@(posedge clk) disable iff (!arst_n)
        ($fell(port.irq_n) && state == IRQ_PULSE)
        |-> ##[1:PULSE_MAX] (port.irq_n || port.event_pulse))
        else $error("pulse outlived its width");
    a_level_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (state == IRQ_HOLD && !port.ack_level) |=> !port.irq_n)
        else $error("level request dropped without acknowledge");
    a_ack_release: assert property (@(posedge clk) disable iff (!arst_n)
        (state == IRQ_HOLD && port.ack_level && !port.event_pulse)[*3]
        |=> port.irq_n)
        else $error("acknowledge did not release request");
endmodule
`default_nettype wire

// >>> sim/config_irq_activity_ctrl_tb.sv
// Self-checking bench for the configuration, interrupt and activity block.
// Assumes the host acknowledge comes from the responder model.
`default_nettype none
module config_irq_activity_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_pkg::*;
    logic clk, arst_n, host_wr, irq_event, interrupt_acknowledge_in;
    logic [ADDR_W-1:0] host_addr;
    logic [REG_W-1:0] host_wdata, host_rdata;
    logic [1:0] hms, inh_a, inh_b, sd_mc, ov_mc, bus_b;
    logic [1:0] tx_block_a, rx_block_a, tx_block_b, rx_block_b;
    logic interrupt_request_n, terminal_active, monitor_active;
    logic monitor_other_involved, activity, ack_en;
    logic [3:0] ack_hold;
    int miscompares = 0;
    int checked = 0;
    int n;

    config_irq_activity_ctrl #(.NRT(2)) DUT (
        .clk(clk), .arst_n(arst_n), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_managed_shutdown(hms),
        .bus_a_inhibit(inh_a), .bus_b_inhibit(inh_b),
        .sel_shutdown_mc(sd_mc), .sel_override_mc(ov_mc),
        .sel_bus_is_b(bus_b), .tx_block_a(tx_block_a),
        .rx_block_a(rx_block_a), .tx_block_b(tx_block_b),
        .rx_block_b(rx_block_b), .irq_event(irq_event),
        .interrupt_acknowledge_in(interrupt_acknowledge_in),
        .interrupt_request_n(interrupt_request_n),
        .terminal_active(terminal_active), .monitor_active(monitor_active),
        .monitor_other_involved(monitor_other_involved),
        .activity(activity));

    host_irq_responder HOST (.clk(clk), .arst_n(arst_n),
        .irq_request_n(interrupt_request_n), .ack_enable(ack_en),
        .ack_hold(ack_hold), .ack(interrupt_acknowledge_in));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task results;
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task check(input string what, input logic [15:0] exp,
               input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge clk);
        host_wr = 1'b0;
        host_addr = 16'h0000;
    endtask

    task rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        host_addr = a;
        @(negedge clk);
        check("host_rdata", exp, host_rdata);
    endtask

    // Mode code strobe for both terminals; outputs settle two edges later
    task mc(input logic [1:0] sd, input logic [1:0] ov, input logic b);
        @(negedge clk);
        sd_mc = sd;
        ov_mc = ov;
        bus_b = {b, b};
        @(negedge clk);
        sd_mc = 2'b00;
        ov_mc = 2'b00;
        @(negedge clk);
    endtask

    task chk_blk(input logic [1:0] ea, input logic [1:0] eb, input logic t);
        check("blocks", {8'h00, ea, ea & {2{~t}}, eb, eb & {2{~t}}},
              {8'h00, tx_block_a, rx_block_a, tx_block_b, rx_block_b});
    endtask

    task irq_pulse;
        @(negedge clk);
        irq_event = 1'b1;
        @(negedge clk);
        irq_event = 1'b0;
    endtask

    // Bounded wait for the request pin; a hang ends the run as a failure
    task wait_irq(input logic level);
        n = 0;
        while (interrupt_request_n !== level && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        if (n == 40)
        begin
            miscompares++;
            results();
        end
    endtask

    initial
    begin
        {arst_n, host_wr, irq_event, terminal_active} = 4'h0;
        {monitor_active, monitor_other_involved, ack_en} = 3'h0;
        {hms, inh_a, inh_b, sd_mc, ov_mc, bus_b} = 12'h000;
        host_addr = 16'h0000;
        host_wdata = 16'h0000;
        ack_hold = 4'h4;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        rd(16'h0000, TOP_CFG_RESET);
        check("irq_n", 16'h0001, {15'h0, interrupt_request_n});
        wr(16'h0000, 16'hffff);
        wr(16'h0004, 16'h0000);
        rd(16'h0000, 16'h000e);
        rd(16'h0004, 16'h0000);
        for (int r = 0; r < 2; r++)
        begin
            wr(16'h0000, r[0] ? 16'h0002 : 16'h0000);
            for (int i = 0; i < 8; i++)
            begin
                @(negedge clk);
                terminal_active = i[2];
                monitor_active = i[1];
                monitor_other_involved = i[0];
                @(negedge clk);
                check("activity", {15'h0, i[2] | (i[1] & (r[0] | i[0]))},
                      {15'h0, activity});
            end
        end
        {terminal_active, monitor_active, monitor_other_involved} = 3'h0;
        for (int t = 0; t < 2; t++)
        begin
            for (int b = 0; b < 2; b++)
            begin
                wr(16'h0000, {12'h000, t[0], 3'b000});
                hms = 2'b10;
                mc(2'b11, 2'b00, b[0]);
                chk_blk(b[0] ? 2'b00 : 2'b01, b[0] ? 2'b01 : 2'b00, t[0]);
                mc(2'b01, 2'b01, b[0]);
                chk_blk(b[0] ? 2'b00 : 2'b01, b[0] ? 2'b01 : 2'b00, t[0]);
                mc(2'b00, 2'b11, b[0]);
                chk_blk(2'b00, 2'b00, t[0]);
                if (b[0])
                    inh_b = 2'b10;
                else
                    inh_a = 2'b10;
                repeat (2) @(negedge clk);
                chk_blk(b[0] ? 2'b00 : 2'b10, b[0] ? 2'b10 : 2'b00, t[0]);
                inh_a = 2'b00;
                inh_b = 2'b00;
                repeat (2) @(negedge clk);
            end
        end
        wr(16'h0000, 16'h0000);
        irq_pulse();
        wait_irq(1'b1);
        check("irq_pulse_cycles", 16'(IRQ_PULSE_CYC), 16'(n));
        wr(16'h0000, 16'h0004);
        ack_hold = 4'h2;
        ack_en = 1'b1;
        irq_pulse();
        repeat (30) @(negedge clk);
        check("irq_n_short_ack", 16'h0000, {15'h0, interrupt_request_n});
        ack_hold = 4'h5;
        wait_irq(1'b1);
        check("irq_n_after_ack", 16'h0001, {15'h0, interrupt_request_n});
        ack_en = 1'b0;
        @(negedge clk);
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        rd(16'h0000, TOP_CFG_RESET);
        results();
    end
endmodule
`default_nettype wire

// >>> sim/host_irq_responder.sv
// Host-side model that answers a held-low interrupt request with an
// acknowledge pulse of a commanded width, then leaves a quiet gap.
// Assumes the request is active low and sampled on the device clock.
`default_nettype none
module host_irq_responder (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Interrupt side
    input wire logic irq_request_n,
    input wire logic ack_enable,
    input wire logic [3:0] ack_hold,
    output logic ack
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;

    // The gap of 9 quiet cycles keeps a stale acknowledge from being
    // counted against the next request after the pin has gone high
    always @(negedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack <= 1'b0;
            cnt <= 0;
        end
        else if (cnt != 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 9)
                ack <= 1'b0;
        end
        else if (ack_enable && !irq_request_n)
        begin
            ack <= 1'b1;
            cnt <= int'(ack_hold) + 8;
        end
    end
endmodule
`default_nettype wire
